/* verilog/ldm_pkg.sv */
// Package of constants and types for the LED digit multiplex driver
`default_nettype none
package ldm_pkg;
	// ==================================================================
	// Timing
	localparam int unsigned LDM_CLK_PERIOD_NS = 40;        // System clock period
	localparam int unsigned LDM_SLOT_TIME_NS  = 2_000_000; // Lit slot of one digit
	localparam int unsigned LDM_LEVELS        = 8;         // Brightness steps per slot
	localparam int unsigned LDM_STEP_CYCLES   =
		LDM_SLOT_TIME_NS / LDM_LEVELS / LDM_CLK_PERIOD_NS;  // Longest time, round down

	// ==================================================================
	// Serial link
	localparam logic [6:0] LDM_DEV_ADDR   = 7'h38; // Default device address
	localparam logic [3:0] LDM_BYTE_BITS  = 4'h8;  // Bits per byte on the link
	localparam logic [2:0] LDM_PTR_CTRL   = 3'h0;  // Sub-address of the control byte
	localparam logic [2:0] LDM_PTR_LAST   = 3'h4;  // Sub-address of the last digit

	// ==================================================================
	// Control byte layout and reset values
	localparam int unsigned LDM_CTRL_STATIC_BIT = 0; // 1 = static mode
	localparam int unsigned LDM_CTRL_LEVEL_LSB  = 4; // Brightness field [6:4]
	localparam logic [2:0]  LDM_LEVEL_RST       = 3'h7;
	localparam logic [7:0]  LDM_PATTERN_RST     = 8'h00;
	localparam logic [7:0]  LDM_SEG_DARK        = 8'hFF; // Common anode: high = dark

	// ==================================================================
	// Types
	typedef struct packed {
		logic       static_mode;
		logic [2:0] level;
	} ldm_ctrl_t;

	typedef enum logic [3:0] {
		ST_SHOW = 4'h1,
		ST_GAP  = 4'h2,
		ST_LOAD = 4'h4,
		ST_IDLE = 4'h8
	} ldm_scan_st_t;

	typedef enum logic [2:0] {
		LK_IDLE = 3'h1,
		LK_RECV = 3'h2,
		LK_ACK  = 3'h4
	} ldm_link_st_t;
endpackage
`default_nettype wire

/* verilog/ldm_digit_store.sv */
// Digit pattern store with one write port and two registered read ports
`timescale 1ns/10ps
`default_nettype none
module ldm_digit_store
	import ldm_pkg::*;
#(
	parameter int unsigned WIDTH = 8,
	parameter int unsigned DEPTH = 4,
	parameter int unsigned AW    = 2
) (
	input  wire logic             sys_clk_in,
	input  wire logic             rst_b_in,
	input  wire logic             wr_en_in,
	input  wire logic [AW-1:0]    wr_addr_in,
	input  wire logic [WIDTH-1:0] wr_data_in,
	input  wire logic [AW-1:0]    rd_addr_a_in,
	input  wire logic [AW-1:0]    rd_addr_b_in,
	output logic      [WIDTH-1:0] rd_data_a_out,
	output logic      [WIDTH-1:0] rd_data_b_out
);
	logic [WIDTH-1:0] mem_ff [DEPTH];

	// ==================================================================
	// Storage, one entry per digit
	genvar g;
	generate
		for (g = 0; g < DEPTH; g++) begin : g_entry
			always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
				if (!rst_b_in) begin
					mem_ff[g] <= WIDTH'(LDM_PATTERN_RST);
				end else if (wr_en_in && (wr_addr_in == AW'(g))) begin
					mem_ff[g] <= wr_data_in;
				end
			end
		end
	endgenerate

	// Registered read data
	always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			rd_data_a_out <= '0;
			rd_data_b_out <= '0;
		end else begin
			rd_data_a_out <= mem_ff[rd_addr_a_in];
			rd_data_b_out <= mem_ff[rd_addr_b_in];
		end
	end
endmodule // ldm_digit_store
`default_nettype wire

/* verilog/ldm_led_digit_mux_driver.sv */
// LED digit multiplex driver: two-wire link slave, pattern store and scan sequencer
// Contract
// - In multiplexed mode brightness has eight levels chosen by the master over the link.
// - Each digit has eight segment lines, seven bars and one decimal point.
// - In multiplexed mode the low bank feeds digits one and two, only one enabled at a time.
// - A digit change turns the lit digit off, then loads the next pattern, then enables it.
// - In multiplexed mode each digit has half of each cycle as its slot, fast enough not to flicker.
// - In static mode digit one runs from the low bank and digit three from the high bank, lit.
// - The master only writes symbol patterns and the control byte; the driver makes all segment and enable signals.
`timescale 1ns/10ps
`default_nettype none
module ldm_led_digit_mux_driver
	import ldm_pkg::*;
#(
	parameter logic [6:0]  DEV_ADDR    = LDM_DEV_ADDR,
	parameter int unsigned STEP_CYCLES = LDM_STEP_CYCLES
) (
	input  wire logic       sys_clk_in,
	input  wire logic       rst_b_in,
	input  wire logic       scl_in,
	input  wire logic       sda_in,
	output logic            sda_out,
	output logic            sda_oe_out,
	output logic [7:0]      segment_bank_low_out,
	output logic [7:0]      segment_bank_high_out,
	output logic            digit_switch_first_out,
	output logic            digit_switch_second_out
);
	// ==================================================================
	// Pin synchronisers, two flops each
	logic [1:0] scl_sync_ff;
	logic [1:0] sda_sync_ff;
	logic       scl_prev_ff;
	logic       sda_prev_ff;

	always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			scl_sync_ff <= 2'h3;
			sda_sync_ff <= 2'h3;
			scl_prev_ff <= 1'b1;
			sda_prev_ff <= 1'b1;
		end else begin
			scl_sync_ff <= {scl_sync_ff[0], scl_in};
			sda_sync_ff <= {sda_sync_ff[0], sda_in};
			scl_prev_ff <= scl_sync_ff[1];
			sda_prev_ff <= sda_sync_ff[1];
		end
	end

	logic scl_rise;
	logic scl_fall;
	logic start_cond;
	logic stop_cond;
	assign scl_rise   = scl_sync_ff[1] && !scl_prev_ff;
	assign scl_fall   = !scl_sync_ff[1] && scl_prev_ff;
	assign start_cond = scl_sync_ff[1] && scl_prev_ff && !sda_sync_ff[1] && sda_prev_ff;
	assign stop_cond  = scl_sync_ff[1] && scl_prev_ff && sda_sync_ff[1] && !sda_prev_ff;

	// ==================================================================
	// Link slave: address, sub-address pointer, then data bytes
	ldm_link_st_t link_st_ff;
	logic [7:0]   shift_ff;
	logic [3:0]   bit_cnt_ff;
	logic         addr_phase_ff;
	logic         ptr_phase_ff;
	logic [2:0]   ptr_ff;
	ldm_ctrl_t    ctrl_ff;
	logic         wr_en_ff;
	logic [1:0]   wr_addr_ff;
	logic [7:0]   wr_data_ff;

	always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			link_st_ff    <= LK_IDLE;
			shift_ff      <= 8'h00;
			bit_cnt_ff    <= 4'h0;
			addr_phase_ff <= 1'b0;
			ptr_phase_ff  <= 1'b0;
			ptr_ff        <= 3'h0;
			ctrl_ff       <= '{static_mode: 1'b0, level: LDM_LEVEL_RST};
			sda_oe_out    <= 1'b0;
			wr_en_ff      <= 1'b0;
			wr_addr_ff    <= 2'h0;
			wr_data_ff    <= 8'h00;
		end else begin
			wr_en_ff <= 1'b0;
			if (start_cond) begin
				link_st_ff    <= LK_RECV;
				bit_cnt_ff    <= 4'h0;
				addr_phase_ff <= 1'b1;
				sda_oe_out    <= 1'b0;
			end else if (stop_cond) begin
				link_st_ff <= LK_IDLE;
				sda_oe_out <= 1'b0;
			end else begin
				case (link_st_ff)
					LK_RECV: begin
						if (scl_rise && (bit_cnt_ff != LDM_BYTE_BITS)) begin
							shift_ff   <= {shift_ff[6:0], sda_sync_ff[1]};
							bit_cnt_ff <= bit_cnt_ff + 4'h1;
						end else if (scl_fall && (bit_cnt_ff == LDM_BYTE_BITS)) begin
							bit_cnt_ff <= 4'h0;
							if (addr_phase_ff) begin
								// Only writes to our address are taken
								addr_phase_ff <= 1'b0;
								ptr_phase_ff  <= 1'b1;
								if ((shift_ff[7:1] == DEV_ADDR) && !shift_ff[0]) begin
									link_st_ff <= LK_ACK;
									sda_oe_out <= 1'b1;
								end else begin
									link_st_ff <= LK_IDLE;
								end
							end else begin
								link_st_ff <= LK_ACK;
								sda_oe_out <= 1'b1;
								if (ptr_phase_ff) begin
									ptr_phase_ff <= 1'b0;
									ptr_ff       <= shift_ff[2:0];
								end else begin
									ptr_ff <= (ptr_ff >= LDM_PTR_LAST) ? LDM_PTR_CTRL
									                                   : ptr_ff + 3'h1;
									if (ptr_ff == LDM_PTR_CTRL) begin
										ctrl_ff.static_mode <= shift_ff[LDM_CTRL_STATIC_BIT];
										ctrl_ff.level <= shift_ff[LDM_CTRL_LEVEL_LSB +: 3];
									end else if (ptr_ff <= LDM_PTR_LAST) begin
										wr_en_ff   <= 1'b1; // Symbol pattern only
										wr_addr_ff <= 2'(ptr_ff - 3'h1);
										wr_data_ff <= shift_ff;
									end
								end
							end
						end
					end
					LK_ACK: begin
						// Release the data line after the acknowledge clock
						if (scl_fall) begin
							sda_oe_out <= 1'b0;
							link_st_ff <= LK_RECV;
						end
					end
					default: begin
						link_st_ff <= LK_IDLE;
					end
				endcase
			end
		end
	end

	// Open-drain data line only ever pulls low
	always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			sda_out <= 1'b0;
		end else begin
			sda_out <= 1'b0;
		end
	end

	// ==================================================================
	// Step divider: one-cycle enable, eight steps per digit slot
	localparam int unsigned DW = $clog2(STEP_CYCLES + 1);
	logic [DW-1:0] div_ff;
	logic          step_tick;
	logic [2:0]    step_ff;
	assign step_tick = (div_ff == DW'(STEP_CYCLES - 1));

	always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			div_ff <= '0;
		end else begin
			div_ff <= step_tick ? '0 : div_ff + DW'(1);
		end
	end

	// ==================================================================
	// Scan sequencer: show, blank, load, show the other digit
	ldm_scan_st_t scan_st_ff;
	logic         sel_ff;
	logic         slot_end;
	assign slot_end = step_tick && (step_ff == 3'h7);

	always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			scan_st_ff <= ST_IDLE;
			sel_ff     <= 1'b1;
			step_ff    <= 3'h0;
		end else begin
			case (scan_st_ff)
				ST_SHOW: begin
					if (step_tick) begin
						step_ff <= step_ff + 3'h1;
					end
					// Equal slots give each digit half the cycle
					if (slot_end) begin
						scan_st_ff <= ST_GAP;
						sel_ff     <= !sel_ff;
					end
				end
				ST_GAP: begin
					scan_st_ff <= ST_LOAD; // Switches go off here
				end
				ST_LOAD: begin
					scan_st_ff <= ST_SHOW; // Pattern lands before enable
					step_ff    <= 3'h0;
				end
				default: begin
					scan_st_ff <= ST_GAP;
					sel_ff     <= 1'b0;
				end
			endcase
		end
	end

	// ==================================================================
	// Pattern store: low bank holds digits one, two; high bank three, four
	logic       rd_sel;
	logic [7:0] pat_low;
	logic [7:0] pat_high;
	assign rd_sel = ctrl_ff.static_mode ? 1'b0 : sel_ff;

	ldm_digit_store #(
		.WIDTH (8),
		.DEPTH (4),
		.AW    (2)
	) u_store (
		.sys_clk_in    (sys_clk_in),
		.rst_b_in      (rst_b_in),
		.wr_en_in      (wr_en_ff),
		.wr_addr_in    (wr_addr_ff),
		.wr_data_in    (wr_data_ff),
		.rd_addr_a_in  ({1'b0, rd_sel}),
		.rd_addr_b_in  ({1'b1, rd_sel}),
		.rd_data_a_out (pat_low),
		.rd_data_b_out (pat_high)
	);

	// ==================================================================
	// Segment lines, active low for common-anode digits
	always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			segment_bank_low_out  <= LDM_SEG_DARK;
			segment_bank_high_out <= LDM_SEG_DARK;
		end else if (ctrl_ff.static_mode || (scan_st_ff == ST_LOAD)) begin
			segment_bank_low_out  <= ~pat_low;  // Seven bars and point
			segment_bank_high_out <= ~pat_high; // Digit three in static mode
		end
	end

	// Digit supply switches: one of the pair lit, brightness by step count in multiplexed mode
	logic lit_now;
	assign lit_now = (scan_st_ff == ST_SHOW) && (step_ff <= ctrl_ff.level);

	always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			digit_switch_first_out  <= 1'b0;
			digit_switch_second_out <= 1'b0;
		end else if (ctrl_ff.static_mode) begin
			digit_switch_first_out  <= 1'b1; // Constantly lit, no switching
			digit_switch_second_out <= 1'b0;
		end else begin
			digit_switch_first_out  <= lit_now && !sel_ff; // Never both on
			digit_switch_second_out <= lit_now && sel_ff;
		end
	end
endmodule // ldm_led_digit_mux_driver
`default_nettype wire

/* tb/ldm_link_master.sv */
// Two-wire bus master model that writes frames to the driver
`timescale 1ns/10ps
`default_nettype none
module ldm_link_master (
	input  wire logic clk_in,
	input  wire logic sda_in,
	output logic      scl_out,
	output logic      sda_low_out
);
	// ====
	// Idle bus: clock stands high, data released to its pull-up
	initial begin
		scl_out = 1'b1;
		sda_low_out = 1'b0;
	end
	// One bus phase, six clocks, above the four-clock minimum
	task automatic ph();
		repeat (6) @(posedge clk_in);
	endtask
	// One byte MSB first, then the acknowledge clock
	task automatic put(input logic [7:0] b, output logic ack);
		for (int i = 7; i >= 0; i--) begin
			ph();
			sda_low_out <= ~b[i];
			ph();
			scl_out <= 1'b1;
			ph();
			scl_out <= 1'b0;
		end
		ph();
		sda_low_out <= 1'b0;
		ph();
		scl_out <= 1'b1;
		ph();
		ack = ~sda_in;
		scl_out <= 1'b0;
	endtask
	// Whole write frame: start, bytes, stop; counts acknowledged bytes
	task automatic frame(input logic [7:0] q[$], output int acks);
		logic a;
		acks = 0;
		sda_low_out <= 1'b1;
		ph();
		scl_out <= 1'b0;
		foreach (q[i]) begin
			put(q[i], a);
			acks += int'(a);
		end
		ph();
		sda_low_out <= 1'b1;
		ph();
		scl_out <= 1'b1;
		ph();
		sda_low_out <= 1'b0;
		ph();
	endtask
endmodule // ldm_link_master
`default_nettype wire

/* tb/ldm_driver_asserts.sv */
// Port assertions for the LED digit multiplex driver
`timescale 1ns/10ps
`default_nettype none
module ldm_driver_asserts
	import ldm_pkg::*;
#(
	parameter int unsigned STEP_CYCLES = LDM_STEP_CYCLES
) (
	input wire logic       sys_clk_in,
	input wire logic       rst_b_in,
	input wire logic       scl_in,
	input wire logic       sda_out,
	input wire logic       sda_oe_out,
	input wire logic [7:0] segment_bank_low_out,
	input wire logic [7:0] segment_bank_high_out,
	input wire logic       digit_switch_first_out,
	input wire logic       digit_switch_second_out
);
	localparam int WIN = 8 * STEP_CYCLES + 8;
	logic [15:0] on_cnt_ff;
	// Length of the running lit period of the second digit
	always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			on_cnt_ff <= 16'h0000;
		end else if (digit_switch_second_out) begin
			on_cnt_ff <= on_cnt_ff + 16'h0001;
		end else begin
			on_cnt_ff <= 16'h0000;
		end
	end
	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (!rst_b_in);
	// Both digit supplies switched off
	sequence s_both_dark;
		!digit_switch_first_out && !digit_switch_second_out;
	endsequence
	// ====
	// Scan and link checks
	a_single_digit_on: assert property (!(digit_switch_first_out && digit_switch_second_out))
		else $error("both digit switches on");
	a_dark_before_next: assert property ($fell(digit_switch_first_out) |-> s_both_dark ##1 s_both_dark)
		else $error("no dark gap after digit change");
	a_pattern_before_on: assert property ($rose(digit_switch_second_out) |->
		$stable(segment_bank_low_out) && $stable(segment_bank_high_out))
		else $error("segments moved as digit turned on");
	a_reset_dark: assert property ($rose(rst_b_in) |-> segment_bank_low_out == LDM_SEG_DARK
		&& segment_bank_high_out == LDM_SEG_DARK && !digit_switch_first_out)
		else $error("display not dark after reset");
	a_on_time_max: assert property (on_cnt_ff <= 8 * STEP_CYCLES)
		else $error("digit lit longer than one slot");
	// Gap and load eat two cycles of the first step; a switch into static mode is no slot end
	a_on_time_min: assert property ($fell(digit_switch_second_out) && !digit_switch_first_out
		|-> on_cnt_ff >= STEP_CYCLES - 2)
		else $error("digit lit shorter than one step");
	a_next_digit_soon: assert property ($fell(digit_switch_first_out) |->
		##[1:WIN] (digit_switch_second_out || digit_switch_first_out))
		else $error("next digit not lit within a slot");
	a_ack_on_low: assert property (($rose(sda_oe_out) || $fell(sda_oe_out)) |-> !scl_in)
		else $error("acknowledge edge while clock high");
	a_ack_held: assert property ($rose(sda_oe_out) |-> sda_oe_out [*4])
		else $error("acknowledge too short");
	a_drive_low: assert property (sda_oe_out |-> !sda_out)
		else $error("data driven high");
endmodule // ldm_driver_asserts
bind ldm_led_digit_mux_driver ldm_driver_asserts #(.STEP_CYCLES(STEP_CYCLES)) u_asserts (
	.sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in), .scl_in(scl_in), .sda_out(sda_out),
	.sda_oe_out(sda_oe_out), .segment_bank_low_out(segment_bank_low_out),
	.segment_bank_high_out(segment_bank_high_out),
	.digit_switch_first_out(digit_switch_first_out),
	.digit_switch_second_out(digit_switch_second_out));
`default_nettype wire

/* tb/ldm_led_digit_mux_driver_tb.sv */
// Testbench for the LED digit multiplex driver
`timescale 1ns/10ps
`default_nettype none
module ldm_led_digit_mux_driver_tb;
	import ldm_pkg::*;
	localparam int S = 4;
	localparam logic [7:0] P [4] = '{8'h3F, 8'h86, 8'h5B, 8'hE6};
	logic       clk, rst_b, scl, m_low, oe, so, d1, d2;
	logic [7:0] lo, hi;
	wire logic  sda = ~(m_low | (oe & ~so));
	int         bad_count = 0;
	int         compares = 0;
	int         n, a, b;
	// ====
	// Clock, design and bus master
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	ldm_led_digit_mux_driver #(.STEP_CYCLES(S)) DUT (.sys_clk_in(clk), .rst_b_in(rst_b),
		.scl_in(scl), .sda_in(sda), .sda_out(so), .sda_oe_out(oe),
		.segment_bank_low_out(lo), .segment_bank_high_out(hi),
		.digit_switch_first_out(d1), .digit_switch_second_out(d2));
	ldm_link_master M (.clk_in(clk), .sda_in(sda), .scl_out(scl), .sda_low_out(m_low));
	// ====
	// Shared tasks
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp) begin
			bad_count++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wrap_up();
		if (bad_count == 0 && compares > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	task automatic send(input logic [7:0] q[$], input int acks);
		M.frame(q, n);
		check("acks", 8'(n), 8'(acks));
	endtask
	// Counts cycles while a switch holds a level, bounded
	task automatic run_len(input bit sec, input logic v, output int c);
		c = 0;
		while ((sec ? d2 : d1) === v) begin
			@(negedge clk);
			c++;
			if (c > 400) begin
				bad_count++;
				wrap_up();
			end
		end
	endtask
	// ====
	// Scenarios
	task automatic t_refuse();
		send('{8'h72, 8'h00, 8'h70}, 0);
		send('{8'h7E, 8'h00, 8'h70}, 0);
		send('{8'h71, 8'h00, 8'h70}, 0);
		send('{8'h70, 8'h05, 8'h3C}, 3);
	endtask
	task automatic t_mux();
		send('{8'h70, 8'h01, P[0], P[1], P[2], P[3], 8'h70}, 7);
		run_len(0, 1, n);
		run_len(0, 0, n);
		check("digit1", lo, ~P[0]);
		check("digit3", hi, ~P[2]);
		run_len(1, 0, n);
		check("digit2", lo, ~P[1]);
		check("digit4", hi, ~P[3]);
		run_len(0, 0, n);
		run_len(0, 1, a);
		run_len(0, 0, b);
		// Gap and load sit inside the eight-step slot, so two slots make the period
		check("period", 8'(a + b), 8'(2 * 8 * S));
		run_len(0, 1, n);
		run_len(1, 0, n);
		run_len(1, 1, n);
		check("half", 8'(n), 8'(a));
	endtask
	task automatic t_level();
		for (int l = 0; l < 8; l++) begin
			send('{8'h70, 8'h00, {1'b0, 3'(l), 4'h0}}, 3);
			run_len(1, 1, n);
			run_len(1, 0, n);
			run_len(1, 1, n);
			// Steps 0..level lit, first step shortened by the gap and load cycles
			check("on time", 8'(n), 8'((l + 1) * S - 2));
		end
	endtask
	task automatic t_static();
		send('{8'h70, 8'h00, 8'h01}, 3);
		repeat (8) @(negedge clk);
		check("static low", lo, ~P[0]);
		check("static high", hi, ~P[2]);
		send('{8'h70, 8'h01, 8'h4F}, 3);
		repeat (70) begin
			@(negedge clk);
			check("static switches", {6'h00, d1, d2}, 8'h02);
		end
		check("static update", lo, 8'hB0);
	endtask
	// ====
	// Main sequence
	initial begin
		rst_b = 1'b0;
		repeat (12) @(posedge clk);
		check("reset low", lo, LDM_SEG_DARK);
		check("reset high", hi, LDM_SEG_DARK);
		check("reset switches", {6'h00, d1, d2}, 8'h00);
		rst_b <= 1'b1;
		repeat (4) @(posedge clk);
		t_refuse();
		t_mux();
		t_level();
		t_static();
		wrap_up();
	end
endmodule // ldm_led_digit_mux_driver_tb
`default_nettype wire
